// *** verilog/dcbd_pkg.sv ***
//Function
//- Code-protect field 0 protects all program memory; 1 leaves it open.
//- Write-protect field 0 blocks user program memory writes; 1 allows them.
//- Two-speed start 1 runs fast RC first, then switches when source ready.
//- PWM lock 1 needs key sequence before PWM register writes; 0 writes freely.
//- Oscillator select decodes 111,110,101,011,010,001,000 to the seven sources.
//- Clock switch field: 1x both off, 01 switching only, 00 both on.
//- Pin-map single-change 1 allows one reconfiguration; 0 allows many.
//- Outside crystal modes, secondary pin is clock output when field is 1.
//- Primary mode: 11 off, 10 high-speed crystal, 01 crystal, 00 external.
//- Watchdog force 1 keeps watchdog and low-power RC running always.
//- Watchdog force 0 lets software enable bit start and stop watchdog.
//- Window-disable 0 gives window mode; 1 gives non-window mode.
//- PLL lock field 1 enables lock wait; 0 disables it.
//- Debug port field 1 enables pull-up on test mode select pin.
package dcbd_pkg;

	// ----------------------------------------
	// Oscillator select codes
	// ----------------------------------------
	localparam logic [2:0] OSC_SEL_FAST_RC = 3'h0;
	localparam logic [2:0] OSC_SEL_FAST_RC_PLL = 3'h1;
	localparam logic [2:0] OSC_SEL_PRIMARY = 3'h2;
	localparam logic [2:0] OSC_SEL_PRIMARY_PLL = 3'h3;
	localparam logic [2:0] OSC_SEL_RESERVED = 3'h4;
	localparam logic [2:0] OSC_SEL_LOW_POWER_RC = 3'h5;
	localparam logic [2:0] OSC_SEL_FAST_RC_DIV16 = 3'h6;
	localparam logic [2:0] OSC_SEL_FAST_RC_DIVN = 3'h7;

	// ----------------------------------------
	// Primary oscillator mode codes
	// ----------------------------------------
	localparam logic [1:0] PRI_MODE_EXTERNAL = 2'h0;
	localparam logic [1:0] PRI_MODE_STD_XTAL = 2'h1;
	localparam logic [1:0] PRI_MODE_FAST_XTAL = 2'h2;
	localparam logic [1:0] PRI_MODE_OFF = 2'h3;

	// ----------------------------------------
	// Clock switch mode codes and reset values
	// ----------------------------------------
	localparam logic [1:0] CKSW_BOTH_ON = 2'h0;
	localparam logic [1:0] CKSW_SWITCH_ONLY = 2'h1;
	localparam int CKSW_OFF_BIT = 1;
	localparam logic [2:0] OSC_SEL_RST = 3'h0;
	localparam logic [1:0] PRI_MODE_RST = 2'h3;
	localparam logic [1:0] CKSW_RST = 2'h3;

	// ----------------------------------------
	// PWM unlock keys, arbitrary plain values
	// ----------------------------------------
	localparam logic [15:0] PWM_KEY_FIRST = 16'hABCD;
	localparam logic [15:0] PWM_KEY_SECOND = 16'h4321;

	// Start-up clock state.
	typedef enum logic [0:0] {
		ST_ON_FAST_RC = 1'b0,
		ST_ON_SELECTED = 1'b1
	} dcbd_start_t;

	// Key sequence state.
	typedef enum logic [1:0] {
		KS_LOCKED = 2'b00,
		KS_FIRST_OK = 2'b01,
		KS_OPEN = 2'b10
	} dcbd_key_t;

endpackage : dcbd_pkg

// *** verilog/dcbd_key_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Link between the decoder and its PWM key sequence checker.
interface dcbd_key_if;
	logic lock_en;
	logic key_valid;
	logic [15:0] key_data;
	logic reg_write;
	logic write_ok;
	modport ctrl (output lock_en, output key_valid, output key_data, output reg_write,
		input write_ok);
	modport unit (input lock_en, input key_valid, input key_data, input reg_write,
		output write_ok);
endinterface : dcbd_key_if
`default_nettype wire

// *** verilog/dcbd_pwm_key.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcbd_pwm_key
	import dcbd_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	dcbd_key_if.unit key
);

	dcbd_key_t state_reg;
	dcbd_key_t state_next;

	// ----------------------------------------
	// Key sequence
	// ----------------------------------------
	// Two key words open one PWM write; a wrong word relocks so a stray
	// write cannot half-open the gate and linger.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			KS_LOCKED: begin
				if (key.key_valid && key.key_data == PWM_KEY_FIRST) begin
					state_next = KS_FIRST_OK;
				end
			end
			KS_FIRST_OK: begin
				if (key.key_valid) begin
					state_next = (key.key_data == PWM_KEY_SECOND) ? KS_OPEN : KS_LOCKED;
				end
			end
			KS_OPEN: begin
				if (key.reg_write) begin
					state_next = KS_LOCKED;
				end
			end
			default: begin
				state_next = KS_LOCKED;
			end
		endcase
	end

	// Register the key state.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			state_reg <= KS_LOCKED;
		end else begin
			state_reg <= state_next;
		end
	end

	// Writes pass freely when unlocked by configuration.
	assign key.write_ok = key.reg_write && (!key.lock_en || state_reg == KS_OPEN);

endmodule : dcbd_pwm_key
`default_nettype wire

// *** verilog/dcbd_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcbd_decoder
	import dcbd_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_code_protect_n,
	input wire logic i_write_protect_n,
	input wire logic i_two_speed_startup_en,
	input wire logic i_pwm_key_lock_en,
	input wire logic [2:0] i_initial_osc_select,
	input wire logic [1:0] i_clock_switch_monitor_mode,
	input wire logic i_pin_map_single_change,
	input wire logic i_osc_pin_function,
	input wire logic [1:0] i_primary_osc_mode,
	input wire logic i_watchdog_force_en,
	input wire logic i_watchdog_window_disable,
	input wire logic i_pll_lock_wait_en,
	input wire logic i_debug_port_en,
	input wire logic i_watchdog_soft_en,
	input wire logic i_selected_osc_ready,
	input wire logic i_pin_map_write,
	input wire logic i_pwm_key_valid,
	input wire logic [15:0] i_pwm_key_data,
	input wire logic i_pwm_reg_write,
	output logic o_code_protect,
	output logic o_write_block,
	output logic [2:0] o_active_osc_select,
	output logic o_startup_on_fast_rc,
	output logic o_osc_select_reserved,
	output logic o_clock_switch_en,
	output logic o_fail_safe_monitor_en,
	output logic o_primary_osc_en,
	output logic o_high_speed_crystal_mode,
	output logic o_standard_crystal_mode,
	output logic o_external_clock_mode,
	output logic o_secondary_osc_clock_out,
	output logic o_secondary_osc_gpio,
	output logic o_pin_map_write_ok,
	output logic o_pwm_reg_write_ok,
	output logic o_watchdog_run,
	output logic o_low_power_rc_on,
	output logic o_watchdog_window_mode,
	output logic o_pll_lock_wait,
	output logic o_debug_pullup_en
);

	// ----------------------------------------
	// Captured configuration image
	// ----------------------------------------
	logic code_protect_n_reg, code_protect_n_next;
	logic write_protect_n_reg, write_protect_n_next;
	logic two_speed_reg, two_speed_next;
	logic pwm_lock_reg, pwm_lock_next;
	logic [2:0] osc_sel_reg, osc_sel_next;
	logic [1:0] cksw_reg, cksw_next;
	logic pin_single_reg, pin_single_next;
	logic osc_pin_fn_reg, osc_pin_fn_next;
	logic [1:0] pri_mode_reg, pri_mode_next;
	logic wdt_force_reg, wdt_force_next;
	logic win_dis_reg, win_dis_next;
	logic pll_lock_reg, pll_lock_next;
	logic debug_en_reg, debug_en_next;

	// Fields hold their value outside reset, so a flash disturbance while
	// running cannot change protection or clocking.
	always_comb begin
		code_protect_n_next = code_protect_n_reg;
		write_protect_n_next = write_protect_n_reg;
		two_speed_next = two_speed_reg;
		pwm_lock_next = pwm_lock_reg;
		osc_sel_next = osc_sel_reg;
		cksw_next = cksw_reg;
		pin_single_next = pin_single_reg;
		osc_pin_fn_next = osc_pin_fn_reg;
		pri_mode_next = pri_mode_reg;
		wdt_force_next = wdt_force_reg;
		win_dis_next = win_dis_reg;
		pll_lock_next = pll_lock_reg;
		debug_en_next = debug_en_reg;
	end

	// The image follows the memory while reset is held, then freezes.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			code_protect_n_reg <= i_code_protect_n;
			write_protect_n_reg <= i_write_protect_n;
			two_speed_reg <= i_two_speed_startup_en;
			pwm_lock_reg <= i_pwm_key_lock_en;
			osc_sel_reg <= i_initial_osc_select;
			cksw_reg <= i_clock_switch_monitor_mode;
			pin_single_reg <= i_pin_map_single_change;
			osc_pin_fn_reg <= i_osc_pin_function;
			pri_mode_reg <= i_primary_osc_mode;
			wdt_force_reg <= i_watchdog_force_en;
			win_dis_reg <= i_watchdog_window_disable;
			pll_lock_reg <= i_pll_lock_wait_en;
			debug_en_reg <= i_debug_port_en;
		end else begin
			code_protect_n_reg <= code_protect_n_next;
			write_protect_n_reg <= write_protect_n_next;
			two_speed_reg <= two_speed_next;
			pwm_lock_reg <= pwm_lock_next;
			osc_sel_reg <= osc_sel_next;
			cksw_reg <= cksw_next;
			pin_single_reg <= pin_single_next;
			osc_pin_fn_reg <= osc_pin_fn_next;
			pri_mode_reg <= pri_mode_next;
			wdt_force_reg <= wdt_force_next;
			win_dis_reg <= win_dis_next;
			pll_lock_reg <= pll_lock_next;
			debug_en_reg <= debug_en_next;
		end
	end

	// ----------------------------------------
	// Oscillator source decode
	// ----------------------------------------
	// The reserved code is mapped to plain fast RC so a mis-programmed part
	// still gets a running clock; the flag lets firmware notice.
	function automatic logic [2:0] osc_legal(input logic [2:0] sel);
		osc_legal = (sel == OSC_SEL_RESERVED) ? OSC_SEL_FAST_RC : sel;
	endfunction : osc_legal

	// ----------------------------------------
	// Two-speed start-up
	// ----------------------------------------
	dcbd_start_t start_reg;
	dcbd_start_t start_next;
	logic pin_used_reg;
	logic pin_used_next;
	logic [2:0] active_reg;
	logic [2:0] active_next;

	// Start on fast RC only when enabled, then move on once the source is ready.
	always_comb begin
		start_next = start_reg;
		case (start_reg)
			ST_ON_FAST_RC: begin
				if (!two_speed_reg || i_selected_osc_ready) begin
					start_next = ST_ON_SELECTED;
				end
			end
			ST_ON_SELECTED: begin
				start_next = ST_ON_SELECTED;
			end
			default: begin
				start_next = ST_ON_FAST_RC;
			end
		endcase
		active_next = (start_next == ST_ON_FAST_RC) ? OSC_SEL_FAST_RC : osc_legal(osc_sel_reg);
		pin_used_next = pin_used_reg | o_pin_map_write_ok;
	end

	// Register start-up and pin-map history.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			start_reg <= ST_ON_FAST_RC;
			active_reg <= OSC_SEL_RST;
			pin_used_reg <= 1'b0;
		end else begin
			start_reg <= start_next;
			active_reg <= active_next;
			pin_used_reg <= pin_used_next;
		end
	end

	assign o_active_osc_select = active_reg;
	assign o_startup_on_fast_rc = (start_reg == ST_ON_FAST_RC) && two_speed_reg;
	assign o_osc_select_reserved = (osc_sel_reg == OSC_SEL_RESERVED);

	// ----------------------------------------
	// Static decodes
	// ----------------------------------------
	assign o_code_protect = !code_protect_n_reg;
	assign o_write_block = !write_protect_n_reg;
	assign o_clock_switch_en = !cksw_reg[CKSW_OFF_BIT];
	assign o_fail_safe_monitor_en = (cksw_reg == CKSW_BOTH_ON);
	assign o_primary_osc_en = (pri_mode_reg != PRI_MODE_OFF);
	assign o_high_speed_crystal_mode = (pri_mode_reg == PRI_MODE_FAST_XTAL);
	assign o_standard_crystal_mode = (pri_mode_reg == PRI_MODE_STD_XTAL);
	assign o_external_clock_mode = (pri_mode_reg == PRI_MODE_EXTERNAL);

	// Crystal modes own the secondary pin, so neither function applies there.
	assign o_secondary_osc_clock_out = osc_pin_fn_reg && !o_high_speed_crystal_mode
		&& !o_standard_crystal_mode;
	assign o_secondary_osc_gpio = !osc_pin_fn_reg && !o_high_speed_crystal_mode
		&& !o_standard_crystal_mode;

	// Only the first reconfiguration passes in single-change mode.
	assign o_pin_map_write_ok = i_pin_map_write && !(pin_single_reg && pin_used_reg);

	// Forced watchdog ignores the software bit entirely.
	assign o_watchdog_run = wdt_force_reg || i_watchdog_soft_en;
	assign o_low_power_rc_on = wdt_force_reg || i_watchdog_soft_en;
	assign o_watchdog_window_mode = !win_dis_reg;
	assign o_pll_lock_wait = pll_lock_reg;
	assign o_debug_pullup_en = debug_en_reg;

	// ----------------------------------------
	// PWM write gate
	// ----------------------------------------
	dcbd_key_if key_bus ();

	assign key_bus.lock_en = pwm_lock_reg;
	assign key_bus.key_valid = i_pwm_key_valid;
	assign key_bus.key_data = i_pwm_key_data;
	assign key_bus.reg_write = i_pwm_reg_write;
	assign o_pwm_reg_write_ok = key_bus.write_ok;

	dcbd_pwm_key u_pwm_key (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.key(key_bus.unit)
	);

endmodule : dcbd_decoder
`default_nettype wire

// *** tb/dcbd_decoder_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcbd_decoder_sva
	import dcbd_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_two_speed_startup_en,
	input wire logic i_pin_map_single_change,
	input wire logic i_pwm_key_lock_en,
	input wire logic i_watchdog_force_en,
	input wire logic i_watchdog_soft_en,
	input wire logic i_selected_osc_ready,
	input wire logic i_pin_map_write,
	input wire logic i_pwm_key_valid,
	input wire logic [15:0] i_pwm_key_data,
	input wire logic i_pwm_reg_write,
	input wire logic o_code_protect,
	input wire logic o_write_block,
	input wire logic [2:0] o_active_osc_select,
	input wire logic o_startup_on_fast_rc,
	input wire logic o_clock_switch_en,
	input wire logic o_fail_safe_monitor_en,
	input wire logic o_primary_osc_en,
	input wire logic o_external_clock_mode,
	input wire logic o_pin_map_write_ok,
	input wire logic o_pwm_reg_write_ok,
	input wire logic o_watchdog_run,
	input wire logic o_low_power_rc_on
);
	logic [3:0] cap;
	// Own copy of the fields, taken at every clock edge while reset is held, so later input changes do not leak in.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			cap <= {i_two_speed_startup_en, i_pin_map_single_change, i_pwm_key_lock_en,
				i_watchdog_force_en};
		end
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_leave;
		o_startup_on_fast_rc && (!cap[3] || i_selected_osc_ready);
	endsequence
	sequence s_pin_used;
		i_pin_map_write && o_pin_map_write_ok && cap[2];
	endsequence
	sequence s_keys;
		(i_pwm_key_valid && i_pwm_key_data == PWM_KEY_FIRST) ##1
			(i_pwm_key_valid && i_pwm_key_data == PWM_KEY_SECOND);
	endsequence
	property p_start_src;
		o_startup_on_fast_rc |-> o_active_osc_select == OSC_SEL_FAST_RC;
	endproperty
	a_start_src: assert property (p_start_src) else $error("start source wrong");
	property p_start_leave;
		s_leave |=> !o_startup_on_fast_rc;
	endproperty
	a_start_leave: assert property (p_start_leave) else $error("start not left");
	property p_start_wait;
		o_startup_on_fast_rc && cap[3] && !i_selected_osc_ready |=> o_startup_on_fast_rc;
	endproperty
	a_start_wait: assert property (p_start_wait) else $error("start left early");
	property p_sel_hold;
		!o_startup_on_fast_rc && $past(i_rst_n) |=> !o_startup_on_fast_rc
			&& $stable(o_active_osc_select);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("selection moved");
	property p_frozen;
		$past(i_rst_n) |-> $stable({o_code_protect, o_write_block, o_clock_switch_en,
			o_fail_safe_monitor_en, o_primary_osc_en, o_external_clock_mode});
	endproperty
	a_frozen: assert property (p_frozen) else $error("decode moved");
	property p_cksw;
		o_fail_safe_monitor_en |-> o_clock_switch_en;
	endproperty
	a_cksw: assert property (p_cksw) else $error("monitor without switching");
	property p_prim;
		o_external_clock_mode |-> o_primary_osc_en;
	endproperty
	a_prim: assert property (p_prim) else $error("external mode while off");
	property p_pin_free;
		!cap[2] |-> o_pin_map_write_ok == i_pin_map_write;
	endproperty
	a_pin_free: assert property (p_pin_free) else $error("pin map grant wrong");
	property p_pin_once;
		s_pin_used ##1 i_pin_map_write |-> !o_pin_map_write_ok;
	endproperty
	a_pin_once: assert property (p_pin_once) else $error("pin map changed twice");
	property p_pwm_free;
		!cap[1] |-> o_pwm_reg_write_ok == i_pwm_reg_write;
	endproperty
	a_pwm_free: assert property (p_pwm_free) else $error("free write refused");
	property p_pwm_open;
		s_keys ##1 (i_pwm_reg_write && !i_pwm_key_valid) |-> o_pwm_reg_write_ok;
	endproperty
	a_pwm_open: assert property (p_pwm_open) else $error("keyed write refused");
	property p_pwm_relock;
		(cap[1] && o_pwm_reg_write_ok) ##1 (i_pwm_reg_write && !i_pwm_key_valid)
			|-> !o_pwm_reg_write_ok;
	endproperty
	a_pwm_relock: assert property (p_pwm_relock) else $error("lock not restored");
	property p_wdt;
		o_watchdog_run == (cap[0] || i_watchdog_soft_en) && o_low_power_rc_on == o_watchdog_run;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog state wrong");
endmodule : dcbd_decoder_sva
bind dcbd_decoder dcbd_decoder_sva i_dcbd_decoder_sva (.i_sys_clk, .i_rst_n,
	.i_two_speed_startup_en, .i_pin_map_single_change, .i_pwm_key_lock_en,
	.i_watchdog_force_en, .i_watchdog_soft_en, .i_selected_osc_ready, .i_pin_map_write,
	.i_pwm_key_valid, .i_pwm_key_data, .i_pwm_reg_write, .o_code_protect, .o_write_block,
	.o_active_osc_select, .o_startup_on_fast_rc, .o_clock_switch_en, .o_fail_safe_monitor_en,
	.o_primary_osc_en, .o_external_clock_mode, .o_pin_map_write_ok, .o_pwm_reg_write_ok,
	.o_watchdog_run, .o_low_power_rc_on);
`default_nettype wire

// *** tb/dcbd_cfg_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcbd_cfg_mem (
	input wire logic i_sys_clk,
	input wire logic i_load,
	input wire logic [16:0] i_word,
	output logic [16:0] o_image
);
	// An erased memory reads all ones, so the debug port field starts set.
	initial o_image = 17'h1_ffff;
	// The reserved select code is never stored; it is programmed as fast RC instead.
	always @(posedge i_sys_clk) begin
		if (i_load) begin
			o_image <= (i_word[6:4] == 3'h4) ? {i_word[16:7], 3'h0, i_word[3:0]} : i_word;
		end
	end
endmodule : dcbd_cfg_mem
`default_nettype wire

// *** tb/dcbd_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcbd_decoder_bench
	import dcbd_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n, ld, sw_en, rdy, pm_w, kv, rw, xtal;
	logic [15:0] kd;
	logic [16:0] word, img, w;
	logic [31:0] seed = 32'h0000_6a4a;
	logic cp, wb, st, rs, cs, fs, pe, hsc, stc, ext, co, gp, pmok, pwok, wr, lp, wm, pl, pu;
	logic [2:0] act;
	// Reference model of the grants: pin-map grants so far and key words since the last lock.
	int pin_grants = 0;
	logic [15:0] keys[$];
	logic key_open;
	int mismatches = 0;
	int n_checks = 0;
	// Clock of 40 ns period.
	always #20 clk = ~clk;
	dcbd_cfg_mem i_dcbd_cfg_mem (.i_sys_clk(clk), .i_load(ld), .i_word(word), .o_image(img));
	dcbd_decoder i_dcbd_decoder (.i_sys_clk(clk), .i_rst_n(rst_n), .i_code_protect_n(img[0]),
		.i_write_protect_n(img[1]), .i_two_speed_startup_en(img[2]), .i_pwm_key_lock_en(img[3]),
		.i_initial_osc_select(img[6:4]), .i_clock_switch_monitor_mode(img[8:7]),
		.i_pin_map_single_change(img[9]), .i_osc_pin_function(img[10]),
		.i_primary_osc_mode(img[12:11]), .i_watchdog_force_en(img[13]),
		.i_watchdog_window_disable(img[14]), .i_pll_lock_wait_en(img[15]),
		.i_debug_port_en(img[16]), .i_watchdog_soft_en(sw_en), .i_selected_osc_ready(rdy),
		.i_pin_map_write(pm_w), .i_pwm_key_valid(kv), .i_pwm_key_data(kd), .i_pwm_reg_write(rw),
		.o_code_protect(cp), .o_write_block(wb), .o_active_osc_select(act),
		.o_startup_on_fast_rc(st), .o_osc_select_reserved(rs), .o_clock_switch_en(cs),
		.o_fail_safe_monitor_en(fs), .o_primary_osc_en(pe), .o_high_speed_crystal_mode(hsc),
		.o_standard_crystal_mode(stc), .o_external_clock_mode(ext),
		.o_secondary_osc_clock_out(co),
		.o_secondary_osc_gpio(gp), .o_pin_map_write_ok(pmok), .o_pwm_reg_write_ok(pwok),
		.o_watchdog_run(wr), .o_low_power_rc_on(lp), .o_watchdog_window_mode(wm),
		.o_pll_lock_wait(pl), .o_debug_pullup_en(pu));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		if (mismatches == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop
	// Each pass programs a random image, sweeps the coded fields, then exercises the grants.
	// The reserved select code (pass 4) is skipped; only the ignored post-release image ~w of pass 3 carries it.
	initial begin
		{rst_n, ld, sw_en, rdy, pm_w, kv, rw} = 7'h00;
		kd = 16'h0000;
		word = 17'h0_0000;
		for (int t = 0; t < 8; t++) begin
			if (t == 4) continue;
			seed = lfsr(seed);
			w = seed[16:0];
			w[6:4] = t[2:0];
			w[8:7] = t[2:1];
			w[12:11] = t[1:0];
			word = w;
			rst_n = 1'b0;
			ld = 1'b1;
			cyc(1);
			ld = 1'b0;
			cyc(11);
			// A new image arrives after release and must be ignored.
			rst_n = 1'b1;
			word = ~w;
			ld = 1'b1;
			cyc(1);
			ld = 1'b0;
			chk(st, w[2]);
			chk(act, w[2] ? 3'h0 : w[6:4]);
			rdy = 1'b1;
			cyc(1);
			rdy = 1'b0;
			chk(st, 1'b0);
			chk(act, w[6:4]);
			chk(rs, 1'b0);
			chk(cp, !w[0]);
			chk(wb, !w[1]);
			chk({cs, fs}, {!w[8], w[8:7] == 2'h0});
			chk({pe, hsc, stc, ext}, {w[12:11] != 2'h3, w[12:11] == 2'h2, w[12:11] == 2'h1,
				w[12:11] == 2'h0});
			xtal = w[11] ^ w[12];
			chk({co, gp}, {!xtal && w[10], !xtal && !w[10]});
			chk({wm, pl, pu}, {!w[14], w[15], w[16]});
			chk({wr, lp}, {w[13], w[13]});
			// Requests stay up over a second edge so that a repeated one is tried.
			pin_grants = 0;
			keys.delete();
			pm_w = 1'b1;
			sw_en = 1'b1;
			#1 chk(pmok, !(w[9] && pin_grants > 0));
			chk({wr, lp}, 2'h3);
			pin_grants++;
			cyc(1);
			chk(pmok, !(w[9] && pin_grants > 0));
			sw_en = 1'b0;
			rw = 1'b1;
			#1 chk(pwok, !w[3]);
			cyc(1);
			pm_w = 1'b0;
			rw = 1'b0;
			kv = 1'b1;
			kd = PWM_KEY_FIRST;
			keys.push_back(kd);
			cyc(1);
			kd = PWM_KEY_SECOND;
			keys.push_back(kd);
			cyc(1);
			kv = 1'b0;
			rw = 1'b1;
			key_open = keys.size() == 2 && keys[0] == PWM_KEY_FIRST && keys[1] == PWM_KEY_SECOND;
			#1 chk(pwok, !w[3] || key_open);
			keys.delete();
			cyc(1);
			chk(pwok, !w[3]);
			cyc(1);
			rw = 1'b0;
		end
		report_and_stop();
	end
	// Cuts a hung run short.
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		report_and_stop();
	end
endmodule : dcbd_decoder_bench
`default_nettype wire
